// ---- hw/bmr_id_rom.sv ----
// eight-byte identity memory with registered read data
// assumes contents fixed by parameter at build time
`default_nettype none

module bmr_id_rom #(
  parameter logic [63:0] ID_VALUE = bmr_pkg::ID_DEFAULT
) (
  input wire logic clk_sys, // system clock
  input wire logic [2:0] addr, // byte index
  output var logic [7:0] rdata_q // byte, one cycle late
);

  logic [7:0] rom [8];

  // unpack the identity word, byte 0 lowest
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      rom[i] = ID_VALUE[8*i +: 8];
    end
  end

  // registered read
  always_ff @(posedge clk_sys)
  begin
    rdata_q <= rom[addr];
  end

endmodule

`default_nettype wire

// ---- hw/bmr_regs.sv ----
// register bank of the coulomb-counting monitor: counters, clear, calibration
// assumes the serial link is decoded into byte requests on clk_sys
`default_nettype none

// Behaviour
// - clear bit set zeroes its counter pair
// - clear bit drops itself after zeroing
// - discharge-time clear drops slow flag, fast rate
// - charge-time clear drops slow flag, fast rate
// - identity bytes read at 0x78 to 0x7f
// - discharge count high 0x6e, low 0x6d
// - charge count high 0x6c, low 0x6b
// - flash program value byte at 0x6f
// - calibration byte holds flags, interval 19..16
// - interval bits 15..8 at 0x76, 7..0 0x75
// - compensation needs enable and success low
// - reset clears compensation enable
// - calibration waits for quiet sense input
// - finish: success low, request cleared
// - success read-only, withdrawn on new request
// - polarity picks discharge or charge counter
// - interval counts in 9.76 ms steps
// - clear bits 4..0 select the pairs
// - time counter wrap toggles slow flag, switching between fast and slow rate
module bmr_regs #(
  parameter int unsigned TIME_TICK_CYC = bmr_pkg::TIME_TICK_CYC,
  parameter int unsigned OFFSET_LSB_CYC = bmr_pkg::OFFSET_LSB_CYC,
  parameter logic [63:0] ID_VALUE = bmr_pkg::ID_DEFAULT
) (
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync, active high
  input wire bmr_pkg::bmr_req_t req, // host byte request
  output var bmr_pkg::bmr_rsp_t rsp, // read answer
  input wire bmr_pkg::bmr_sense_t sense, // analog front-end events
  input wire logic [8:0] temperature, // temperature reading
  output var bmr_pkg::bmr_ctrl_t ctrl, // controls to front end
  output var logic stat_o, // status pin level
  output var logic stat_oe // status pin pull-down on
);
  import bmr_pkg::*;

  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_RUN} bmr_cal_state_t;

  // ===========================================================
  // functions
  function automatic logic [15:0] bump(input logic [15:0] v, input logic a,
                                       input logic b);
    bump = 16'(v + {15'h0000, a} + {15'h0000, b});
  endfunction

  function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction

  // ===========================================================
  // state
  logic [CLEAR_REQ_W-1:0] clear_req_q;
  logic stat_bit_q, por_bit_q;
  logic short_q, regoff_q, mode_rsvd_q, slow_chg_q, slow_dis_q;
  logic [2:0] wake_sel_q;
  logic [15:0] chg_cnt_q, dis_cnt_q, sd_cnt_q, ct_cnt_q, dt_cnt_q;
  logic [7:0] flash_command_q, fp_value_q, fp_loc_q;
  logic flash_command_strobe_q, cal_start_q;
  logic comp_en_q, cal_ok_n_q, polarity_q;
  logic [19:0] interval_q, comp_cnt_q;
  bmr_cal_state_t cal_state_q;
  logic [31:0] tick_cnt_q, lsb_cnt_q;
  logic base_tick_q, lsb_tick_q;
  logic [7:0] slow_div_q;
  logic rd_pend_q;
  logic [6:0] rd_addr_q;
  logic [7:0] rom_q, rd_mux;
  logic wr, rd, wr_clear, wr_cal, slow_tick, comp_active, comp_evt;
  logic ct_step, dt_step, ct_wrap, dt_wrap;

  assign wr = req.valid & req.write;
  assign rd = req.valid & ~req.write;
  assign wr_clear = wr && (req.addr == ADDR_CLEAR);
  assign wr_cal = wr && (req.addr == ADDR_CAL_CTRL);

  // ===========================================================
  // host-written bytes
  // clear pair requests
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      clear_req_q <= '0;
      stat_bit_q <= STAT_RST;
      por_bit_q <= POR_RST;
    end
    else if (wr_clear)
    begin
      clear_req_q <= req.data[CLEAR_REQ_W-1:0];
      stat_bit_q <= req.data[CLEAR_STAT];
      por_bit_q <= req.data[CLEAR_POR];
    end
    else
    begin
      clear_req_q <= '0;
    end
  end

  // mode byte writable fields
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      short_q <= 1'b0;
      regoff_q <= 1'b0;
      wake_sel_q <= WAKE_SEL_RST;
      mode_rsvd_q <= 1'b0;
    end
    else if (wr && (req.addr == ADDR_MODE))
    begin
      short_q <= req.data[MODE_SHORT];
      regoff_q <= req.data[MODE_REGOFF];
      wake_sel_q <= req.data[MODE_WAKE_HI:MODE_WAKE_LO];
      mode_rsvd_q <= req.data[MODE_RSVD];
    end
  end

  // flash bytes and command strobe
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      flash_command_q <= BYTE_ZERO;
      fp_value_q <= BYTE_ZERO;
      fp_loc_q <= BYTE_ZERO;
      flash_command_strobe_q <= 1'b0;
    end
    else
    begin
      flash_command_strobe_q <= wr && (req.addr == ADDR_FLASH_CMD);
      if (wr && (req.addr == ADDR_FLASH_CMD))
        flash_command_q <= req.data;
      if (wr && (req.addr == ADDR_FP_VALUE))
        fp_value_q <= req.data;
      if (wr && (req.addr == ADDR_FP_LOC))
        fp_loc_q <= req.data;
    end
  end

  // calibration control and interval bytes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      comp_en_q <= 1'b0;
      polarity_q <= 1'b0;
      interval_q <= '0;
    end
    else
    begin
      if (wr_cal)
      begin
        comp_en_q <= req.data[CAL_COMP_EN];
        polarity_q <= req.data[CAL_POL];
        interval_q[19:16] <= req.data[CAL_IV_HI:0];
      end
      if (wr && (req.addr == ADDR_IV_MID))
        interval_q[15:8] <= req.data;
      if (wr && (req.addr == ADDR_IV_LO))
        interval_q[7:0] <= req.data;
    end
  end

  // ===========================================================
  // calibration sequencer
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cal_state_q <= CAL_IDLE;
      cal_ok_n_q <= CAL_OK_N_RST;
      cal_start_q <= 1'b0;
    end
    else
    begin
      cal_start_q <= 1'b0;
      if (wr_cal && req.data[CAL_REQ])
      begin
        cal_state_q <= CAL_WAIT;
        cal_ok_n_q <= 1'b1;
      end
      else
      begin
        case (cal_state_q)
          CAL_WAIT:
          begin
            if (sense.below_wake)
            begin
              cal_state_q <= CAL_RUN;
              cal_start_q <= 1'b1;
            end
          end
          CAL_RUN:
          begin
            if (sense.cal_done)
            begin
              cal_state_q <= CAL_IDLE;
              cal_ok_n_q <= 1'b0;
            end
          end
          default:
            cal_state_q <= CAL_IDLE;
        endcase
      end
    end
  end

  // ===========================================================
  // offset compensation timer
  // active only when enabled and calibrated
  assign comp_active = comp_en_q & ~cal_ok_n_q;
  assign comp_evt = comp_active && lsb_tick_q && (interval_q != '0) &&
                    (({1'b0, comp_cnt_q} + 21'd1) >= {1'b0, interval_q});

  always_ff @(posedge clk_sys)
  begin
    if (reset || !comp_active)
    begin
      lsb_cnt_q <= '0;
      lsb_tick_q <= 1'b0;
    end
    else
    begin
      lsb_tick_q <= (lsb_cnt_q == 32'(OFFSET_LSB_CYC - 1));
      if (lsb_cnt_q == 32'(OFFSET_LSB_CYC - 1))
        lsb_cnt_q <= '0;
      else
        lsb_cnt_q <= lsb_cnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset || !comp_active || comp_evt)
      comp_cnt_q <= '0;
    else if (lsb_tick_q)
      comp_cnt_q <= comp_cnt_q + 20'd1;
  end

  // ===========================================================
  // charge, discharge, self-discharge counts
  // clear zeroes the pair
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      chg_cnt_q <= CNT_ZERO;
      dis_cnt_q <= CNT_ZERO;
      sd_cnt_q <= CNT_ZERO;
    end
    else
    begin
      if (clear_req_q[CLEAR_CC])
        chg_cnt_q <= CNT_ZERO;
      else
        chg_cnt_q <= bump(chg_cnt_q, sense.charge_pulse, comp_evt & ~polarity_q);
      if (clear_req_q[CLEAR_DC])
        dis_cnt_q <= CNT_ZERO;
      else
        dis_cnt_q <= bump(dis_cnt_q, sense.discharge_pulse, comp_evt & polarity_q);
      if (clear_req_q[CLEAR_SD])
        sd_cnt_q <= CNT_ZERO;
      else
        sd_cnt_q <= bump(sd_cnt_q, sense.self_dis_tick, 1'b0);
    end
  end

  // ===========================================================
  // time base for the activity timers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tick_cnt_q <= '0;
      base_tick_q <= 1'b0;
      slow_div_q <= BYTE_ZERO;
    end
    else
    begin
      base_tick_q <= (tick_cnt_q == 32'(TIME_TICK_CYC - 1));
      if (tick_cnt_q == 32'(TIME_TICK_CYC - 1))
        tick_cnt_q <= '0;
      else
        tick_cnt_q <= tick_cnt_q + 32'd1;
      if (base_tick_q)
        slow_div_q <= (slow_div_q == SLOW_LAST) ? BYTE_ZERO : slow_div_q + 8'd1;
    end
  end

  assign slow_tick = base_tick_q && (slow_div_q == SLOW_LAST);
  assign ct_step = sense.charging && (slow_chg_q ? slow_tick : base_tick_q);
  assign dt_step = sense.discharging && (slow_dis_q ? slow_tick : base_tick_q);
  assign ct_wrap = ct_step && (ct_cnt_q == CNT_MAX) && !clear_req_q[CLEAR_CT];
  assign dt_wrap = dt_step && (dt_cnt_q == CNT_MAX) && !clear_req_q[CLEAR_DT];

  // charge and discharge activity timers with slow flags
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ct_cnt_q <= CNT_ZERO;
      dt_cnt_q <= CNT_ZERO;
      slow_chg_q <= 1'b0;
      slow_dis_q <= 1'b0;
    end
    else
    begin
      if (clear_req_q[CLEAR_CT])
      begin
        ct_cnt_q <= CNT_ZERO;
        slow_chg_q <= 1'b0;
      end
      else
      begin
        ct_cnt_q <= bump(ct_cnt_q, ct_step, 1'b0);
        if (ct_wrap)
          slow_chg_q <= ~slow_chg_q;
      end
      if (clear_req_q[CLEAR_DT])
      begin
        dt_cnt_q <= CNT_ZERO;
        slow_dis_q <= 1'b0;
      end
      else
      begin
        dt_cnt_q <= bump(dt_cnt_q, dt_step, 1'b0);
        if (dt_wrap)
          slow_dis_q <= ~slow_dis_q;
      end
    end
  end

  // ===========================================================
  // read path: rom byte ready one cycle after request
  bmr_id_rom #(.ID_VALUE(ID_VALUE)) u_id_rom (
    .clk_sys(clk_sys),
    .addr(req.addr[2:0]),
    .rdata_q(rom_q)
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end
    else
    begin
      rd_pend_q <= rd;
      if (rd)
        rd_addr_q <= req.addr;
    end
  end

  // read data select, unmapped reads zero
  always_comb
  begin
    rd_mux = BYTE_ZERO;
    case (rd_addr_q)
      ADDR_TEMP_LO: rd_mux = temperature[7:0];
      ADDR_TEMP_HI: rd_mux = {7'h00, temperature[8]};
      ADDR_FLASH_CMD: rd_mux = flash_command_q;
      ADDR_CLEAR: rd_mux = {1'b0, por_bit_q, stat_bit_q, clear_req_q};
      ADDR_MODE: rd_mux = {short_q, regoff_q, slow_chg_q, slow_dis_q, wake_sel_q,
                           mode_rsvd_q};
      ADDR_CT_LO: rd_mux = pick(ct_cnt_q, 1'b0);
      ADDR_CT_HI: rd_mux = pick(ct_cnt_q, 1'b1);
      ADDR_DT_LO: rd_mux = pick(dt_cnt_q, 1'b0);
      ADDR_DT_HI: rd_mux = pick(dt_cnt_q, 1'b1);
      ADDR_SD_LO: rd_mux = pick(sd_cnt_q, 1'b0);
      ADDR_SD_HI: rd_mux = pick(sd_cnt_q, 1'b1);
      ADDR_CC_LO: rd_mux = pick(chg_cnt_q, 1'b0);
      ADDR_CC_HI: rd_mux = pick(chg_cnt_q, 1'b1);
      ADDR_DC_LO: rd_mux = pick(dis_cnt_q, 1'b0);
      ADDR_DC_HI: rd_mux = pick(dis_cnt_q, 1'b1);
      ADDR_FP_VALUE: rd_mux = fp_value_q;
      ADDR_FP_LOC: rd_mux = fp_loc_q;
      ADDR_IV_LO: rd_mux = interval_q[7:0];
      ADDR_IV_MID: rd_mux = interval_q[15:8];
      ADDR_CAL_CTRL: rd_mux = {comp_en_q, cal_state_q != CAL_IDLE, cal_ok_n_q,
                               polarity_q, interval_q[19:16]};
      default:
      begin
        if (rd_addr_q[6:3] == ID_PAGE)
          rd_mux = rom_q;
      end
    endcase
  end

  // answer register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rsp <= '0;
    else
    begin
      rsp.valid <= rd_pend_q;
      rsp.data <= rd_pend_q ? rd_mux : rsp.data;
    end
  end

  // ===========================================================
  // outputs
  always_comb
  begin
    ctrl.sense_short_enable = short_q;
    ctrl.regulator_disable = regoff_q;
    ctrl.wake_threshold_select = wake_sel_q;
    ctrl.cal_start = cal_start_q;
    ctrl.flash_cmd_strobe = flash_command_strobe_q;
    ctrl.flash_command_byte = flash_command_q;
    ctrl.flash_program_value_byte = fp_value_q;
    ctrl.flash_program_location_byte = fp_loc_q;
  end

  // open drain: bit low pulls the pin
  assign stat_o = 1'b0;
  assign stat_oe = ~stat_bit_q;

  // ===========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_clear_zero;
    wr_clear && req.data[CLEAR_DC] |-> ##2 dis_cnt_q == CNT_ZERO;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("pair not zeroed");

  property p_clear_drop;
    (clear_req_q != '0) && !wr_clear |=> clear_req_q == '0;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("clear bit stuck");

  property p_dt_clear;
    clear_req_q[CLEAR_DT] |=> !slow_dis_q && dt_cnt_q == CNT_ZERO;
  endproperty
  a_dt_clear: assert property (p_dt_clear) else $error("dt clear failed");

  property p_ct_clear;
    clear_req_q[CLEAR_CT] |=> !slow_chg_q && ct_cnt_q == CNT_ZERO;
  endproperty
  a_ct_clear: assert property (p_ct_clear) else $error("ct clear failed");

  property p_rom_read;
    rd && req.addr[6:3] == ID_PAGE |-> ##2 rsp.valid &&
      rsp.data == 8'(ID_VALUE >> {$past(req.addr[2:0], 2), 3'b000});
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("id byte wrong");

  property p_dis_read;
    rd && req.addr == ADDR_DC_HI |-> ##2 rsp.valid && rsp.data == pick($past(dis_cnt_q), 1'b1);
  endproperty
  a_dis_read: assert property (p_dis_read) else $error("dis high wrong");

  property p_comp_gate;
    !(comp_en_q && !cal_ok_n_q) && !sense.discharge_pulse && !clear_req_q[CLEAR_DC]
      |=> dis_cnt_q == $past(dis_cnt_q);
  endproperty
  a_comp_gate: assert property (p_comp_gate) else $error("comp not gated");

  property p_reset_comp;
    disable iff (1'b0) reset |=> !comp_en_q && cal_state_q == CAL_IDLE;
  endproperty
  a_reset_comp: assert property (p_reset_comp) else $error("reset state");

  property p_cal_start;
    ctrl.cal_start |-> $past(sense.below_wake) && cal_state_q == CAL_RUN;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("early cal start");

  property p_cal_done;
    cal_state_q == CAL_RUN && sense.cal_done && !wr_cal |=> !cal_ok_n_q &&
      cal_state_q == CAL_IDLE;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("cal finish");

  property p_cal_withdraw;
    wr_cal && req.data[CAL_REQ] |=> cal_ok_n_q && cal_state_q == CAL_WAIT;
  endproperty
  a_cal_withdraw: assert property (p_cal_withdraw) else $error("no withdraw");

  property p_comp_dir;
    comp_evt && polarity_q && !sense.discharge_pulse && !clear_req_q[CLEAR_DC]
      |=> dis_cnt_q == 16'($past(dis_cnt_q) + 16'd1);
  endproperty
  a_comp_dir: assert property (p_comp_dir) else $error("comp dir");

  property p_restart;
    comp_evt |=> comp_cnt_q == '0 && !lsb_tick_q;
  endproperty
  a_restart: assert property (p_restart) else $error("timer restart");

  property p_wrap;
    dt_wrap |=> slow_dis_q != $past(slow_dis_q) && dt_cnt_q == CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag");

  c_clear: cover property (wr_clear ##2 clear_req_q == '0);
  c_cal: cover property (cal_state_q == CAL_RUN ##1 !cal_ok_n_q);
  c_comp: cover property (comp_evt);

endmodule

`default_nettype wire

// ---- pkg/bmr_pkg.sv ----
// register map, field positions, reset values and timing of the monitor bank
// assumes a single 100 MHz clock and a byte-wide host register port
`default_nettype none

package bmr_pkg;

  // ===========================================================
  // register addresses (command byte address field)
  localparam logic [6:0] ADDR_TEMP_LO = 7'h60;
  localparam logic [6:0] ADDR_TEMP_HI = 7'h61;
  localparam logic [6:0] ADDR_FLASH_CMD = 7'h62;
  localparam logic [6:0] ADDR_CLEAR = 7'h63;
  localparam logic [6:0] ADDR_MODE = 7'h64;
  localparam logic [6:0] ADDR_CT_LO = 7'h65;
  localparam logic [6:0] ADDR_CT_HI = 7'h66;
  localparam logic [6:0] ADDR_DT_LO = 7'h67;
  localparam logic [6:0] ADDR_DT_HI = 7'h68;
  localparam logic [6:0] ADDR_SD_LO = 7'h69;
  localparam logic [6:0] ADDR_SD_HI = 7'h6a;
  localparam logic [6:0] ADDR_CC_LO = 7'h6b;
  localparam logic [6:0] ADDR_CC_HI = 7'h6c;
  localparam logic [6:0] ADDR_DC_LO = 7'h6d;
  localparam logic [6:0] ADDR_DC_HI = 7'h6e;
  localparam logic [6:0] ADDR_FP_VALUE = 7'h6f;
  localparam logic [6:0] ADDR_FP_LOC = 7'h70;
  localparam logic [6:0] ADDR_IV_LO = 7'h75;
  localparam logic [6:0] ADDR_IV_MID = 7'h76;
  localparam logic [6:0] ADDR_CAL_CTRL = 7'h77;
  localparam logic [3:0] ID_PAGE = 4'hf; // 0x78..0x7f

  // ===========================================================
  // counter clear byte fields
  localparam int CLEAR_DC = 0;
  localparam int CLEAR_CC = 1;
  localparam int CLEAR_SD = 2;
  localparam int CLEAR_DT = 3;
  localparam int CLEAR_CT = 4;
  localparam int CLEAR_STAT = 5;
  localparam int CLEAR_POR = 6;
  localparam int CLEAR_REQ_W = 5;

  // mode / wake byte fields
  localparam int MODE_SHORT = 7;
  localparam int MODE_REGOFF = 6;
  localparam int MODE_SLOW_CHG = 5;
  localparam int MODE_SLOW_DIS = 4;
  localparam int MODE_WAKE_HI = 3;
  localparam int MODE_WAKE_LO = 1;
  localparam int MODE_RSVD = 0;

  // calibration control byte fields
  localparam int CAL_COMP_EN = 7;
  localparam int CAL_REQ = 6;
  localparam int CAL_OK_N = 5;
  localparam int CAL_POL = 4;
  localparam int CAL_IV_HI = 3;

  // ===========================================================
  // reset values
  localparam logic [2:0] WAKE_SEL_RST = 3'h7;
  localparam logic CAL_OK_N_RST = 1'b1;
  localparam logic STAT_RST = 1'b1;
  localparam logic POR_RST = 1'b1;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ===========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TIME_TICK_NS = 878_900_000; // 0.8789 s
  localparam int unsigned TIME_TICK_CYC = TIME_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned OFFSET_LSB_NS = 9_760_000; // 9.76 ms
  localparam int unsigned OFFSET_LSB_CYC = OFFSET_LSB_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_PER_HOUR = 4096;
  localparam int unsigned SLOW_PER_HOUR = 16;
  localparam logic [7:0] SLOW_LAST = 8'((FAST_PER_HOUR / SLOW_PER_HOUR) - 1);

  // arbitrary identity contents, no meaning
  localparam logic [63:0] ID_DEFAULT = 64'h0123_4567_89ab_cdef;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } bmr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } bmr_rsp_t;

  typedef struct packed {
    logic charge_pulse;
    logic discharge_pulse;
    logic charging;
    logic discharging;
    logic self_dis_tick;
    logic below_wake;
    logic cal_done;
  } bmr_sense_t;

  typedef struct packed {
    logic sense_short_enable;
    logic regulator_disable;
    logic [2:0] wake_threshold_select;
    logic cal_start;
    logic flash_cmd_strobe;
    logic [7:0] flash_command_byte;
    logic [7:0] flash_program_value_byte;
    logic [7:0] flash_program_location_byte;
  } bmr_ctrl_t;

endpackage

`default_nettype wire

// ---- verif/bmr_host_model.sv ----
// host side model: issues byte requests to the register bank
// assumes the bench calls its tasks; requests change at falling edges
`default_nettype none

module bmr_host_model
  import bmr_pkg::*;
(
  input wire logic clk_sys, // system clock
  output var bmr_pkg::bmr_req_t req // request to the bank
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // bit 7 picks write, 6..0 address
  task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= {1'b1, w, a, d};
    @(posedge clk_sys);
    // one request only: drop valid after the taking edge
    @(negedge clk_sys);
    req <= '0;
  endtask

  // release the port between bursts
  task automatic idle();
    @(negedge clk_sys);
    req <= '0;
  endtask
endmodule

`default_nettype wire

// ---- verif/test_bmr_regs.sv ----
// self-checking bench for the monitor register bank
// assumes bmr_pkg and the host model are compiled first
`default_nettype none

module test_bmr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import bmr_pkg::*;

  localparam logic [63:0] ID_TB = 64'h1122_3344_5566_7788; // arbitrary value
  logic clk_sys;
  logic reset;
  bmr_req_t req;
  bmr_rsp_t rsp;
  bmr_sense_t sense;
  bmr_ctrl_t ctrl;
  logic [8:0] temperature;
  logic stat_oe;
  logic cal_seen;
  logic [7:0] v;
  logic [7:0] lo_q[$];
  logic [7:0] hi_q[$];
  logic [6:0] a_q[$];
  int err_total;
  int tests_run;
  int cycles;
  int seed;
  int n;

  // one time tick per cycle so a time counter wrap fits in the run
  bmr_regs #(.TIME_TICK_CYC(1), .OFFSET_LSB_CYC(3), .ID_VALUE(ID_TB)) u_bmr_regs (
    .clk_sys(clk_sys), .reset(reset), .req(req), .rsp(rsp), .sense(sense),
    .temperature(temperature), .ctrl(ctrl), .stat_o(), .stat_oe(stat_oe));
  bmr_host_model u_bmr_host_model (.clk_sys(clk_sys), .req(req));

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // compare tasks
  task automatic cmp_byte(input logic [6:0] a, input logic [7:0] lo, hi, seen);
    tests_run++;
    if ((seen >= lo && seen <= hi) !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED reg %h expected %h..%h seen %h", a, lo, hi, seen);
    end
  endtask

  task automatic chk(input string nm, input logic exp, input logic seen);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
    end
  endtask

  // read with expected range noted first
  task automatic rd(input logic [6:0] a, input logic [7:0] lo, input logic [7:0] hi);
    a_q.push_back(a);
    lo_q.push_back(lo);
    hi_q.push_back(hi);
    u_bmr_host_model.op(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_bmr_host_model.op(1'b1, a, d);
  endtask

  task automatic finish_test();
    err_total += lo_q.size();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // answer watcher, calibration start seen, hang limit
  always @(posedge clk_sys)
  begin
    cycles++;
    if (ctrl.cal_start === 1'b1)
      cal_seen = 1'b1;
    if (rsp.valid === 1'b1 && a_q.size() == 0)
      chk("unexpected_answer", 1'b0, 1'b1);
    else if (rsp.valid === 1'b1)
      cmp_byte(a_q.pop_front(), lo_q.pop_front(), hi_q.pop_front(), rsp.data);
    if (cycles == 90000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'h050d53ca;
    reset = 1'b1;
    sense = '0;
    temperature = 9'h000;
    cal_seen = 1'b0;
    cycles = 0;
    err_total = 0;
    tests_run = 0;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    temperature = 9'($random(seed));
    rd(ADDR_CLEAR, 8'h60, 8'h60);
    rd(ADDR_MODE, 8'h0e, 8'h0e);
    rd(ADDR_CAL_CTRL, 8'h20, 8'h20);
    rd(7'h72, 8'h00, 8'h00);
    rd(ADDR_TEMP_LO, temperature[7:0], temperature[7:0]);
    rd(ADDR_TEMP_HI, {7'h00, temperature[8]}, {7'h00, temperature[8]});
    for (int i = 0; i < 8; i++)
      rd({ID_PAGE, 3'(i)}, ID_TB[8*i+:8], ID_TB[8*i+:8]);
    // counts: charge every cycle, discharge and self ticks every other
    n = 200 + ($unsigned($random(seed)) % 200);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys);
      sense = {2'b11, 2'b11, 1'b0, 2'b00};
      sense.discharge_pulse = i[0];
      sense.self_dis_tick = i[0];
    end
    @(negedge clk_sys);
    sense = '0;
    rd(ADDR_CC_LO, n[7:0], n[7:0]);
    rd(ADDR_CC_HI, n[15:8], n[15:8]);
    rd(ADDR_DC_LO, n[8:1], n[8:1]);
    rd(ADDR_DC_HI, 8'h00, 8'h00);
    rd(ADDR_CT_LO, n[7:0], n[7:0]);
    v = 8'($random(seed));
    wr(ADDR_FP_VALUE, v);
    wr(ADDR_CC_LO, 8'hff);
    wr(ADDR_IV_MID, ~v);
    rd(ADDR_FP_VALUE, v, v);
    rd(ADDR_IV_MID, ~v, ~v);
    rd(ADDR_CC_LO, n[7:0], n[7:0]);
    // all five pairs cleared by one write
    wr(ADDR_CLEAR, 8'h7f);
    u_bmr_host_model.idle();
    rd(ADDR_CLEAR, 8'h60, 8'h60);
    for (int a = 'h65; a <= 'h6e; a++)
      rd(7'(a), 8'h00, 8'h00);
    rd(ADDR_MODE, 8'h0e, 8'h0e);
    // calibration, then positive offset every 2 steps
    wr(ADDR_IV_LO, 8'h02);
    wr(ADDR_IV_MID, 8'h00);
    wr(ADDR_CAL_CTRL, 8'hd0);
    u_bmr_host_model.idle();
    repeat (5) @(negedge clk_sys);
    rd(ADDR_CAL_CTRL, 8'hf0, 8'hf0);
    chk("cal_start_early", 1'b0, cal_seen);
    sense.below_wake = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("cal_start", 1'b1, cal_seen);
    sense.cal_done = 1'b1;
    @(negedge clk_sys);
    sense = '0;
    rd(ADDR_CAL_CTRL, 8'h90, 8'h90);
    wr(ADDR_CLEAR, 8'h63);
    u_bmr_host_model.idle();
    repeat (70) @(negedge clk_sys);
    rd(ADDR_DC_LO, 8'd9, 8'd13);
    rd(ADDR_CC_LO, 8'h00, 8'h00);
    wr(ADDR_CAL_CTRL, 8'h10);
    wr(ADDR_CLEAR, 8'h61);
    u_bmr_host_model.idle();
    repeat (40) @(negedge clk_sys);
    rd(ADDR_DC_LO, 8'h00, 8'h00);
    // discharge-time wrap, then clear it with the status pin turned on
    sense.discharging = 1'b1;
    repeat (65600) @(negedge clk_sys);
    sense = '0;
    rd(ADDR_MODE, 8'h1e, 8'h1e);
    rd(ADDR_DT_HI, 8'h00, 8'h00);
    wr(ADDR_CLEAR, 8'h48);
    chk("stat_oe", 1'b1, stat_oe);
    rd(ADDR_MODE, 8'h0e, 8'h0e);
    rd(ADDR_DT_LO, 8'h00, 8'h00);
    rd(ADDR_CLEAR, 8'h40, 8'h40);
    u_bmr_host_model.idle();
    repeat (4) @(negedge clk_sys);
    finish_test();
  end
endmodule

`default_nettype wire
